//--- src/i2c_ss_pkg.sv
/*
  Shared constants and carrier types for the I2C start/stop generator,
  bus-status detector and flag register.
  Assumes a 250 MHz reference clock and word-aligned AHB-Lite access.
*/
`default_nettype none

package i2c_ss_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int COND_HOLD_NS = 4000;
  localparam int COND_HOLD_CYC =
    (COND_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 10;
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(COND_HOLD_CYC - 1);

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [29:0] IDX_CTRL = 30'h000fff50;
  localparam logic [29:0] IDX_FLAG = 30'h000fff52;
  localparam logic [29:0] IDX_EV_STAT = 30'h000fff54;
  localparam logic [29:0] IDX_EV_MASK = 30'h000fff55;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_EN_BIT = 7;
  localparam int FLAG_RSV_BIT = 0;
  localparam int FLAG_ISE_BIT = 1;
  localparam int FLAG_BUSY_BIT = 6;
  localparam int FLAG_FAIL_BIT = 7;
  localparam int EV_START_DET = 0;
  localparam int EV_STOP_DET = 1;
  localparam int EV_START_FAIL = 2;
  localparam int EV_START_GEN = 3;
  localparam int EV_STOP_GEN = 4;
  localparam int EV_W = 5;
  localparam logic [EV_W-1:0] EV_RESET = 5'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int HTRANS_ACT_BIT = 1;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;

  typedef struct packed {
    logic start;
    logic stop;
  } cond_t;

endpackage : i2c_ss_pkg

`default_nettype wire

//--- src/cond_detect.sv
/*
  Samples the SCL and SDA pins and reports start and stop conditions.
  Assumes pins are asynchronous to the reference clock.
*/
`default_nettype none

module cond_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus pins
  input wire i2c_ss_pkg::line_t pin_in,
  // Filtered levels and condition pulses
  output var i2c_ss_pkg::line_t level,
  output var i2c_ss_pkg::cond_t cond
);
  import i2c_ss_pkg::*;

  line_t s1_q, s2_q, s3_q;
  line_t lvl_d;
  cond_t cond_d;

  // A level counts once the second and third stages agree
  assign lvl_d.scl = (s2_q.scl == s3_q.scl) ? s3_q.scl : level.scl;
  assign lvl_d.sda = (s2_q.sda == s3_q.sda) ? s3_q.sda : level.sda;
  assign cond_d.start = level.scl & lvl_d.scl & level.sda & ~lvl_d.sda;
  assign cond_d.stop = level.scl & lvl_d.scl & ~level.sda & lvl_d.sda;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 2'b11;
      s2_q <= 2'b11;
      s3_q <= 2'b11;
      level <= 2'b11;
      cond <= 2'b00;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= lvl_d;
      cond <= cond_d;
    end
  end

endmodule : cond_detect

`default_nettype wire

//--- src/cond_gen.sv
/*
  Drives start, repeated start and stop sequences onto SCL and SDA.
  Assumes open-drain pins: a high enable pulls the line low.
*/
`default_nettype none

module cond_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic en,
  input wire logic start_go,
  input wire logic stop_go,
  // Status
  output logic ready,
  output logic start_done,
  output logic stop_done,
  // Pull-low enables
  output var i2c_ss_pkg::line_t drive
);
  import i2c_ss_pkg::*;

  typedef enum logic [3:0] {
    G_IDLE, G_HELD, G_RS_SDA, G_RS_SCL, G_ST_SDA, G_ST_SCL,
    G_SP_SDA, G_SP_SCL, G_SP_REL
  } gen_state_t;

  gen_state_t state_q, state_d;
  logic [HOLD_W-1:0] cnt_q, cnt_d;
  line_t drive_d;
  logic tdone;

  assign tdone = (cnt_q == HOLD_LAST);
  assign ready = (state_q == G_IDLE) || (state_q == G_HELD);
  assign cnt_d = (state_d != state_q) ? '0 :
                 (tdone ? cnt_q : cnt_q + 1'b1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      G_IDLE: begin
        if (stop_go) state_d = G_SP_SDA;
        else if (start_go) state_d = G_ST_SDA;
      end
      G_HELD: begin
        if (stop_go) state_d = G_SP_SDA;
        else if (start_go) state_d = G_RS_SDA;
      end
      G_RS_SDA: if (tdone) state_d = G_RS_SCL;
      G_RS_SCL: if (tdone) state_d = G_ST_SDA;
      G_ST_SDA: if (tdone) state_d = G_ST_SCL;
      G_ST_SCL: if (tdone) state_d = G_HELD;
      G_SP_SDA: if (tdone) state_d = G_SP_SCL;
      G_SP_SCL: if (tdone) state_d = G_SP_REL;
      G_SP_REL: if (tdone) state_d = G_IDLE;
    endcase
    if (!en) state_d = G_IDLE;
  end

  // Pull-low pattern per state
  always_comb begin
    unique case (state_d)
      G_HELD, G_ST_SCL, G_SP_SDA: drive_d = 2'b11;
      G_RS_SDA: drive_d = 2'b10;
      G_ST_SDA, G_SP_SCL: drive_d = 2'b01;
      default: drive_d = 2'b00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= G_IDLE;
      cnt_q <= '0;
      drive <= 2'b00;
      start_done <= 1'b0;
      stop_done <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      drive <= drive_d;
      start_done <= (state_q == G_ST_SCL) && (state_d == G_HELD);
      stop_done <= (state_q == G_SP_REL) && (state_d == G_IDLE);
    end
  end

endmodule : cond_gen

`default_nettype wire

//--- src/i2c_start_stop_status.sv
/*
  I2C start/stop generator, bus-status detector and flag register,
  with an AHB-Lite register slave and a masked event interrupt.
  Assumes open-drain SCL/SDA resolved outside, a single AHB master,
  and pins asynchronous to REF_CLK.
*/
// Operation
// - Start request bit set launches a start, unless refused as below.
// - Reservation off and bus busy: drop start, raise start-fail flag.
// - Stop request bit set launches a stop condition.
// - Busy tracked by start/stop detection, seeded from initial-start.
// - Control: stop request bit 0, start request 1, enable 7.
// - Flag: fail 7, busy 6, initial-start 1, reserve-off 0; rest zero.
// - Failed start sets fail flag and clears the start request bit; here a request already pending stays set.
// - Busy sets on start detect, or enabling with initial-start at 0.
// - On enabling, busy starts 0 if initial-start is 1, else 1.
// - Start allowed once the bus is seen released.
// - Initial-start cleared by start detect or software; set by software.
// - Reserve-off bit: software only, reset to 0.
// - Fail and busy flags ignore software writes.
`default_nettype none

module i2c_start_stop_status (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // I2C bus pins (open drain)
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Condition pulses to the shift logic
  output logic START_DET,
  output logic STOP_DET,
  // Interrupt
  output logic IRQ
);
  import i2c_ss_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic stop_req_q, start_req_q, en_q;
  logic stop_req_d, start_req_d, en_d;
  logic fail_q, busy_q, ise_q, rsv_q;
  logic fail_d, busy_d, ise_d, rsv_d;
  logic [EV_W-1:0] ev_stat_q, ev_stat_d, ev_mask_q, ev_mask_d;
  logic [EV_W-1:0] ev_set;
  logic [31:0] rdata_d;
  logic wr_pend_q;
  logic [29:0] wr_idx_q;
  logic access, wr_ctrl, wr_flag, wr_stat, wr_mask;
  logic [7:0] ctrl_rd, flag_rd;
  logic en_rise, en_fall, owned;
  logic start_wr, start_refused, start_ok, stop_ok;
  logic start_go, stop_go;
  logic gen_ready, gen_start_done, gen_stop_done;
  logic det_start, det_stop;
  line_t pin_in, pin_level, gen_drive;
  cond_t det_cond;

  function automatic logic [29:0] word_index(input logic [31:0] addr);
    word_index = addr[31:2];
  endfunction : word_index

  // ----------------------------------------------------------------------
  // Bus pin sampling and condition detection
  // ----------------------------------------------------------------------
  assign pin_in.scl = SCL_IN;
  assign pin_in.sda = SDA_IN;

  cond_detect u_detect (
    .clk(REF_CLK),
    .rst(RST),
    .pin_in(pin_in),
    .level(pin_level),
    .cond(det_cond)
  );

  // Detector stays idle while the unit is disabled
  assign det_start = det_cond.start & en_q;
  assign det_stop = det_cond.stop & en_q;

  // ----------------------------------------------------------------------
  // AHB-Lite address phase
  // ----------------------------------------------------------------------
  assign access = HSEL & HTRANS[HTRANS_ACT_BIT] & HREADY;

  assign ctrl_rd = {en_q, 5'h00, start_req_q, stop_req_q};
  assign flag_rd = {fail_q, busy_q, 4'h0, ise_q, rsv_q};

  always_comb begin
    unique case (word_index(HADDR))
      IDX_CTRL: rdata_d = {24'h000000, ctrl_rd};
      IDX_FLAG: rdata_d = {24'h000000, flag_rd};
      IDX_EV_STAT: rdata_d = {27'h0000000, ev_stat_q};
      IDX_EV_MASK: rdata_d = {27'h0000000, ev_mask_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------------
  // AHB-Lite data phase write strobes
  // ----------------------------------------------------------------------
  assign wr_ctrl = wr_pend_q && (wr_idx_q == IDX_CTRL);
  assign wr_flag = wr_pend_q && (wr_idx_q == IDX_FLAG);
  assign wr_stat = wr_pend_q && (wr_idx_q == IDX_EV_STAT);
  assign wr_mask = wr_pend_q && (wr_idx_q == IDX_EV_MASK);

  // ----------------------------------------------------------------------
  // Enable and request decoding
  // ----------------------------------------------------------------------
  assign en_d = wr_ctrl ? HWDATA[CTRL_EN_BIT] : en_q;
  assign en_rise = en_d & ~en_q;
  assign en_fall = ~en_d & en_q;

  // The bus belongs to us between our start and our stop
  assign owned = gen_ready & (gen_drive == 2'b11);

  assign start_wr = wr_ctrl & HWDATA[CTRL_START_BIT] & en_d;
  // Refused request never latches; the bit keeps its previous value
  assign start_refused = start_wr & rsv_q & busy_q & ~owned;

  // Pending start waits for a released bus or our own held bus
  assign start_ok = ~busy_q | owned;
  assign stop_ok = gen_ready;

  assign stop_go = stop_req_q & stop_ok & en_q;
  assign start_go = start_req_q & start_ok & gen_ready & ~stop_req_q
                    & en_q;

  // ----------------------------------------------------------------------
  // Control register next state
  // ----------------------------------------------------------------------
  always_comb begin
    start_req_d = start_req_q;
    if (start_go) start_req_d = 1'b0;
    if (start_wr & ~start_refused) start_req_d = 1'b1;
    if (~en_d) start_req_d = 1'b0;
  end

  always_comb begin
    stop_req_d = stop_req_q;
    if (stop_go) stop_req_d = 1'b0;
    if (wr_ctrl & HWDATA[CTRL_STOP_BIT] & en_d) stop_req_d = 1'b1;
    if (~en_d) stop_req_d = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Flag register next state
  // ----------------------------------------------------------------------
  always_comb begin
    fail_d = fail_q;
    if (start_wr | en_fall) fail_d = 1'b0;
    if (start_refused) fail_d = 1'b1;
  end

  always_comb begin
    busy_d = busy_q;
    if (det_stop) busy_d = 1'b0;
    if (det_start) busy_d = 1'b1;
    if (en_rise) busy_d = ~ise_q;
    if (~en_d) busy_d = 1'b0;
  end

  // Software bits; the flag bits 7 and 6 take no write
  always_comb begin
    ise_d = ise_q;
    rsv_d = rsv_q;
    if (wr_flag) begin
      ise_d = HWDATA[FLAG_ISE_BIT];
      rsv_d = HWDATA[FLAG_RSV_BIT];
    end
    if (det_start) ise_d = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------------
  assign ev_set[EV_START_DET] = det_start;
  assign ev_set[EV_STOP_DET] = det_stop;
  assign ev_set[EV_START_FAIL] = start_refused;
  assign ev_set[EV_START_GEN] = gen_start_done;
  assign ev_set[EV_STOP_GEN] = gen_stop_done;

  // Write one to clear; a new event in the same cycle wins
  assign ev_stat_d = (wr_stat ? (ev_stat_q & ~HWDATA[EV_W-1:0])
                              : ev_stat_q) | ev_set;
  assign ev_mask_d = wr_mask ? HWDATA[EV_W-1:0] : ev_mask_q;

  // ----------------------------------------------------------------------
  // Condition generator
  // ----------------------------------------------------------------------
  cond_gen u_gen (
    .clk(REF_CLK),
    .rst(RST),
    .en(en_q),
    .start_go(start_go),
    .stop_go(stop_go),
    .ready(gen_ready),
    .start_done(gen_start_done),
    .stop_done(gen_stop_done),
    .drive(gen_drive)
  );

  assign SCL_OE = gen_drive.scl;
  assign SDA_OE = gen_drive.sda;

  // ----------------------------------------------------------------------
  // Bus slave registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_q <= access & HWRITE;
      wr_idx_q <= word_index(HADDR);
      if (access & ~HWRITE) HRDATA <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Control and flag registers
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      en_q <= REG_RESET[CTRL_EN_BIT];
      start_req_q <= REG_RESET[CTRL_START_BIT];
      stop_req_q <= REG_RESET[CTRL_STOP_BIT];
      fail_q <= REG_RESET[FLAG_FAIL_BIT];
      busy_q <= REG_RESET[FLAG_BUSY_BIT];
      ise_q <= REG_RESET[FLAG_ISE_BIT];
      rsv_q <= REG_RESET[FLAG_RSV_BIT];
    end else begin
      en_q <= en_d;
      start_req_q <= start_req_d;
      stop_req_q <= stop_req_d;
      fail_q <= fail_d;
      busy_q <= busy_d;
      ise_q <= ise_d;
      rsv_q <= rsv_d;
    end
  end

  // ----------------------------------------------------------------------
  // Events, interrupt and pin outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ev_stat_q <= EV_RESET;
      ev_mask_q <= EV_RESET;
      IRQ <= 1'b0;
      START_DET <= 1'b0;
      STOP_DET <= 1'b0;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end else begin
      ev_stat_q <= ev_stat_d;
      ev_mask_q <= ev_mask_d;
      IRQ <= |(ev_stat_d & ev_mask_d);
      START_DET <= det_start;
      STOP_DET <= det_stop;
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
    end
  end

endmodule : i2c_start_stop_status

`default_nettype wire

//--- bench/ss_checker.sv
/*
  Port-level assertions for the start/stop generator and bus flags.
  Assumes binding onto the design top; pins resolved with pull-ups.
*/
`default_nettype none

module ss_checker (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Register bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Bus pins and condition pulses
  input wire logic SCL_IN,
  input wire logic SCL_OUT,
  input wire logic SCL_OE,
  input wire logic SDA_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  input wire logic START_DET,
  input wire logic STOP_DET
);
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_ss_pkg::*;

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  logic rd_flag_q;
  wire rd_flag_d = HSEL && HTRANS[1] && HREADY && !HWRITE &&
    (HADDR[31:2] == IDX_FLAG);
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) rd_flag_q <= 1'b0;
    else rd_flag_q <= rd_flag_d;
  end

  sequence s_scl_pull;
    $rose(SCL_OE);
  endsequence
  sequence s_sda_held;
    SDA_OE && $past(SDA_OE, 8);
  endsequence
  sequence s_sda_let;
    $fell(SDA_OE) && !SCL_OE && !$past(SCL_OE);
  endsequence

  AST_START_ORDER: assert property (s_scl_pull |-> s_sda_held)
    else $error("clock pulled before data in start");
  AST_STOP_ORDER: assert property (s_sda_let |-> !$past(SCL_OE, 8))
    else $error("data released too soon in stop");
  AST_START_WIRE: assert property (START_DET |-> SCL_IN && !SDA_IN)
    else $error("start pulse without start on wire");
  AST_STOP_WIRE: assert property (STOP_DET |-> SCL_IN && SDA_IN)
    else $error("stop pulse without stop on wire");
  AST_START_PULSE: assert property (START_DET |=> !START_DET)
    else $error("start pulse too long");
  AST_DET_EXCL: assert property (!(START_DET && STOP_DET))
    else $error("start and stop pulses together");
  AST_FLAG_ZERO: assert property (rd_flag_q |->
    HRDATA[5:2] == 4'h0 && HRDATA[31:8] == 24'h0)
    else $error("reserved flag bits not zero");
  AST_PINS_LOW: assert property (!SCL_OUT && !SDA_OUT)
    else $error("pin output level not low");
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
    else $error("bus response not ready okay");
endmodule : ss_checker

`default_nettype wire

//--- bench/i2c_far_party.sv
/*
  Other master on the bus: makes a start, clocks a few bits, stops.
  Assumes a wired-AND bus with pull-ups resolved by the bench.
*/
`default_nettype none

module i2c_far_party (
  // Commands
  input wire logic go_start,
  input wire logic go_stop,
  // Pull-low enables
  output logic scl_pull,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // Data changes only while the clock is low; 48 ns link clock
  always @(posedge go_start) begin
    sda_pull = 1'b1;
    #48;
    repeat (4) begin
      scl_pull = 1'b1;
      #12;
      sda_pull = ~sda_pull;
      #12;
      scl_pull = 1'b0;
      #24;
    end
    scl_pull = 1'b1;
  end
  always @(posedge go_stop) begin
    sda_pull = 1'b1;
    #24;
    scl_pull = 1'b0;
    #48;
    sda_pull = 1'b0;
  end
endmodule : i2c_far_party

`default_nettype wire

//--- bench/i2c_start_stop_status_test.sv
/*
  Self-checking bench: register bus, own start/stop, far-party traffic.
  Assumes the design package; the bus resolves as a pulled-up wired AND.
*/
`default_nettype none

module i2c_start_stop_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  import i2c_ss_pkg::*;

  logic clk, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic scl_oe, sda_oe, scl_o, sda_o, start_det, stop_det;
  logic go_start, go_stop, p_scl, p_sda;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  wire scl = ~scl_oe & ~p_scl;
  wire sda = ~sda_oe & ~p_sda;

  i2c_start_stop_status dut_u (.REF_CLK(clk), .RST(rst), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .SCL_IN(scl), .SCL_OUT(scl_o),
    .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
    .START_DET(start_det), .STOP_DET(stop_det), .IRQ(irq));
  i2c_far_party far_u (.go_start(go_start), .go_stop(go_stop),
    .scl_pull(p_scl), .sda_pull(p_sda));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [29:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, rdat);
  endtask : wr
  task automatic rd_chk(input logic [29:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, rdat);
    chk(rdat, e);
  endtask : rd_chk
  task automatic wait_det(input bit stop);
    int i;
    for (i = 0; i < 6000; i++) begin
      @(posedge clk);
      if ((stop ? stop_det : start_det) === 1'b1) break;
    end
    chk(32'(i < 6000), 32'h1);
  endtask : wait_det
  task automatic pulse(input bit stop);
    @(posedge clk);
    if (stop) go_stop <= 1'b1;
    else go_start <= 1'b1;
    @(posedge clk);
    go_start <= 1'b0;
    go_stop <= 1'b0;
  endtask : pulse

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    rd_chk(IDX_CTRL, 32'h0);
    rd_chk(IDX_FLAG, 32'h0);
    rd_chk(IDX_EV_STAT, 32'h0);
    rd_chk(IDX_EV_MASK, 32'h0);
    rd_chk(30'h1, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : t_reset
  task automatic t_flags;
    wr(IDX_FLAG, 32'hff);
    rd_chk(IDX_FLAG, 32'h03);
    wr(IDX_FLAG, 32'h0);
    rd_chk(IDX_FLAG, 32'h0);
  endtask : t_flags
  task automatic t_own;
    wr(IDX_EV_MASK, 32'h1f);
    wr(IDX_FLAG, 32'h02);
    wr(IDX_CTRL, 32'h80);
    rd_chk(IDX_FLAG, 32'h02);
    wr(IDX_CTRL, 32'h82);
    wait_det(1'b0);
    repeat (2100) @(posedge clk);
    rd_chk(IDX_FLAG, 32'h40);
    rd_chk(IDX_EV_STAT, 32'h09);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_EV_MASK, 32'h0);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_EV_MASK, 32'h1f);
    wr(IDX_EV_STAT, 32'h1f);
    rd_chk(IDX_EV_STAT, 32'h0);
    wr(IDX_CTRL, 32'h81);
    wait_det(1'b1);
    rd_chk(IDX_FLAG, 32'h0);
    repeat (1100) @(posedge clk);
    wr(IDX_CTRL, 32'h0);
  endtask : t_own
  task automatic t_refuse;
    wr(IDX_EV_STAT, 32'h1f);
    wr(IDX_FLAG, 32'h01);
    wr(IDX_CTRL, 32'h80);
    rd_chk(IDX_FLAG, 32'h41);
    wr(IDX_CTRL, 32'h82);
    rd_chk(IDX_FLAG, 32'hc1);
    rd_chk(IDX_CTRL, 32'h80);
    rd_chk(IDX_EV_STAT, 32'h04);
    wr(IDX_CTRL, 32'h0);
    rd_chk(IDX_FLAG, 32'h01);
    wr(IDX_FLAG, 32'h0);
  endtask : t_refuse
  task automatic t_party;
    wr(IDX_FLAG, 32'h02);
    wr(IDX_CTRL, 32'h80);
    pulse(1'b0);
    wait_det(1'b0);
    rd_chk(IDX_FLAG, 32'h40);
    wr(IDX_CTRL, 32'h82);
    rd_chk(IDX_CTRL, 32'h82);
    rd_chk(IDX_FLAG, 32'h40);
    // Far party must finish clocking its bits before it stops
    repeat (100) @(posedge clk);
    pulse(1'b1);
    wait_det(1'b1);
    wait_det(1'b0);
    wr(IDX_CTRL, 32'h81);
    wait_det(1'b1);
    rd_chk(IDX_FLAG, 32'h0);
    wr(IDX_CTRL, 32'h0);
  endtask : t_party

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    rst = 1'b1;
    {hsel, hwrite, go_start, go_stop} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_flags;
    t_own;
    t_refuse;
    t_party;
    close_out;
  end
endmodule : i2c_start_stop_status_test

bind i2c_start_stop_status ss_checker chk_u (.REF_CLK(REF_CLK), .RST(RST),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .START_DET(START_DET),
  .STOP_DET(STOP_DET));

`default_nettype wire
